/* rtl/dio_lines.sv */
// dio_lines: six-line digital i/o port with fixed roles and manual functions
// assumes a synchronous register port and pins already synchronous to clk
//
// Contract
// - six lines, each picked by index for setup and reading.
// - after reset lines one to three fixed role, four to six input.
// - fixed role accepted only on lines one to three.
// - line one fixed role detects falling, rising or either edge.
// - line two fixed role pulses 10 us per finished measurement.
// - line three fixed role pulses 10 us on any protection trip.
// - manual high drives the line high.
// - manual low drives the line low.
// - manual input releases the driver and samples the pin.
// - reading an input line returns its present level.
// - reading a non-input line returns nothing and raises error 508.
module dio_lines
    import dio_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic [3:0]           addr,
    input  wire logic [15:0]          wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic [15:0]               rdata,
    input  wire logic                 meas_done,
    input  wire logic                 over_voltage_trip,
    input  wire logic                 over_current_trip,
    input  wire logic                 over_temp_trip,
    input  wire logic                 sense_reversed,
    input  wire logic [NUM_LINES-1:0] line_in,
    output logic [NUM_LINES-1:0]      line_out,
    output logic [NUM_LINES-1:0]      line_oe,
    output logic                      trigger_event,
    output logic                      irq
);
    logic [11:0]          func_q;
    logic [1:0]           edge_q;
    logic [15:0]          rdata_q;
    logic [15:0]          result_q;
    logic [9:0]           err_q;
    logic [IRQ_W-1:0]     stat_q;
    logic [IRQ_W-1:0]     stat_d;
    logic [IRQ_W-1:0]     en_q;
    logic [NUM_LINES-1:0] out_q;
    logic [NUM_LINES-1:0] oe_q;
    logic [NUM_LINES-1:0] out_d;
    logic [NUM_LINES-1:0] oe_d;
    logic                 trig_q;
    logic                 irq_q;

    pulse_bus_if done_bus ();
    pulse_bus_if prot_bus ();

    // per-line function view
    line_fn_t fn [NUM_LINES];
    for (genvar i = 0; i < NUM_LINES; i++) begin : g_fn
        assign fn[i] = line_fn_t'(func_q[2*i+1:2*i]);
    end

    // register strobes
    logic wr_func;
    logic wr_edge;
    logic rd_query;
    logic wr_clr;
    logic wr_en;
    assign wr_func  = wr && addr == ADDR_FUNC;
    assign wr_edge  = wr && addr == ADDR_EDGE;
    assign wr_clr   = wr && addr == ADDR_IRQ_CLR;
    assign wr_en    = wr && addr == ADDR_IRQ_EN;
    assign rd_query = wr && addr == ADDR_QUERY;

    // function write, fixed role refused on lines four to six
    logic [11:0] func_d;
    logic        func_bad;
    always_comb begin
        func_d   = func_q;
        func_bad = 1'b0;
        if (wr_func) begin
            for (int i = 0; i < NUM_LINES; i++) begin
                if (fn_legal(3'(i), wdata[2*i+1 -: 2])) begin
                    func_d[2*i+1 -: 2] = wdata[2*i+1 -: 2];
                end else begin
                    func_bad = 1'b1;
                end
            end
        end
    end

    // manual input query: line index in wdata[2:0], 1 to 6
    logic [2:0] q_idx;
    logic       q_range;
    logic       q_input;
    logic       q_level;
    assign q_idx   = wdata[2:0] - 3'd1;
    assign q_range = wdata[2:0] >= 3'd1 && wdata[2:0] <= 3'(NUM_LINES);
    assign q_input = q_range && fn[q_idx] == FN_INPUT;
    assign q_level = line_in[q_idx];
    logic q_fail;
    assign q_fail = rd_query && !q_input;

    // fixed-role events; other functions drop them
    logic trig_hit;
    logic prot_any;
    logic fixed1;
    logic fixed2;
    logic fixed3;
    assign fixed1   = fn[0] == FN_FIXED;
    assign fixed2   = fn[1] == FN_FIXED;
    assign fixed3   = fn[2] == FN_FIXED;
    assign prot_any = over_voltage_trip | over_current_trip |
                      over_temp_trip | sense_reversed;
    assign done_bus.fire = fixed2 & meas_done;
    assign prot_bus.fire = fixed3 & prot_any;

    edge_detect u_trig (
        .clk   (clk),
        .reset (reset),
        .level (line_in[0]),
        .arm   (fixed1),
        .sel   (edge_q),
        .hit   (trig_hit)
    );

    pulse_stretch #(.LEN(PULSE_CYC)) u_done (
        .clk   (clk),
        .reset (reset),
        .bus   (done_bus)
    );

    pulse_stretch #(.LEN(PULSE_CYC)) u_prot (
        .clk   (clk),
        .reset (reset),
        .bus   (prot_bus)
    );

    // pin drivers per function
    always_comb begin
        out_d = '0;
        oe_d  = '0;
        for (int i = 0; i < NUM_LINES; i++) begin
            unique case (fn[i])
                FN_HIGH: begin
                    out_d[i] = 1'b1;
                    oe_d[i]  = 1'b1;
                end
                FN_LOW: begin
                    out_d[i] = 1'b0;
                    oe_d[i]  = 1'b1;
                end
                FN_INPUT: begin
                    oe_d[i]  = 1'b0;
                end
                FN_FIXED: begin
                    // line one stays released as trigger input
                    oe_d[i]  = (i == 1) || (i == 2);
                    out_d[i] = (i == 1) ? done_bus.active :
                               (i == 2) ? prot_bus.active : 1'b0;
                end
            endcase
        end
    end

    // sticky status; a new event wins over a clear in the same cycle
    assign stat_d = (stat_q & ~(wr_clr ? wdata[IRQ_W-1:0] : '0)) |
                    {q_fail | func_bad, prot_bus.fire,
                     done_bus.fire, trig_hit};

    // read mux
    logic [15:0] rmux;
    always_comb begin
        unique case (addr)
            ADDR_FUNC:     rmux = {4'h0, func_q};
            ADDR_EDGE:     rmux = {14'h0000, edge_q};
            ADDR_RESULT:   rmux = result_q;
            ADDR_ERROR:    rmux = {6'h00, err_q};
            ADDR_IRQ_STAT: rmux = {12'h000, stat_q};
            ADDR_IRQ_EN:   rmux = {12'h000, en_q};
            ADDR_PINS:     rmux = {10'h000, line_in};
            default:       rmux = 16'h0000;
        endcase
    end

    // control and configuration registers
    always_ff @(posedge clk) begin
        if (reset) begin
            func_q <= FUNC_RESET;
            edge_q <= EDGE_RESET;
            en_q   <= '0;
        end else begin
            func_q <= func_d;
            if (wr_edge && wdata[1:0] != 2'b11) edge_q <= wdata[1:0];
            if (wr_en) en_q <= wdata[IRQ_W-1:0];
        end
    end

    // query result: bit 15 valid, bit 0 level; failure leaves no data
    always_ff @(posedge clk) begin
        if (reset) begin
            result_q <= '0;
            err_q    <= '0;
        end else if (rd_query) begin
            if (q_input) begin
                result_q <= {1'b1, 14'h0000, q_level};
                err_q    <= '0;
            end else begin
                result_q <= '0;
                err_q    <= ERR_NOT_INPUT;
            end
        end
    end

    // outputs straight from flops
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q  <= '0;
            stat_q   <= '0;
            out_q    <= '0;
            oe_q     <= '0;
            trig_q   <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            rdata_q  <= rd ? rmux : 16'h0000;
            stat_q   <= stat_d;
            out_q    <= out_d;
            oe_q     <= oe_d;
            trig_q   <= trig_hit;
            irq_q    <= |(stat_d & en_q);
        end
    end

    assign rdata         = rdata_q;
    assign line_out      = out_q;
    assign line_oe       = oe_q;
    assign trigger_event = trig_q;
    assign irq           = irq_q;

endmodule : dio_lines

/* rtl/dio_pkg.sv */
// dio_pkg: constants, register map and types for the six-line digital i/o port
// assumes a single 25 MHz clock and a synchronous active-high reset
package dio_pkg;

    localparam int unsigned NUM_LINES     = 6;
    localparam int unsigned FIXED_LINES   = 3;
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned PULSE_US      = 10;
    // the cycle count truncates the clock to whole MHz and never falls below one cycle
    localparam int unsigned PULSE_CYC     =
        (PULSE_US * (CLK_HZ / 1_000_000) + 0) > 0 ?
        PULSE_US * (CLK_HZ / 1_000_000) : 1;
    localparam int unsigned PULSE_W       = 9;

    localparam logic [9:0]  ERR_NOT_INPUT = 10'h1FC;  // 508

    // function codes, two bits per line
    typedef enum logic [1:0] {
        FN_FIXED = 2'b00,
        FN_HIGH  = 2'b01,
        FN_LOW   = 2'b10,
        FN_INPUT = 2'b11
    } line_fn_t;

    // trigger sensitivity for line one in its fixed role
    typedef enum logic [1:0] {
        EDGE_FALL = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_BOTH = 2'b10
    } edge_sel_t;
    localparam logic [1:0]  EDGE_RESET    = 2'b00;

    // register offsets
    localparam logic [3:0] ADDR_FUNC     = 4'h0;
    localparam logic [3:0] ADDR_EDGE     = 4'h1;
    localparam logic [3:0] ADDR_QUERY    = 4'h2;
    localparam logic [3:0] ADDR_RESULT   = 4'h3;
    localparam logic [3:0] ADDR_ERROR    = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
    localparam logic [3:0] ADDR_IRQ_EN   = 4'h6;
    localparam logic [3:0] ADDR_IRQ_CLR  = 4'h7;
    localparam logic [3:0] ADDR_PINS     = 4'h8;

    // function register: line n at bits [2n-1:2n-2], lines 1-3 fixed, 4-6 input
    localparam logic [11:0] FUNC_RESET   = 12'hFC0;

    // interrupt status bits
    localparam int unsigned IRQ_TRIG     = 0;
    localparam int unsigned IRQ_DONE     = 1;
    localparam int unsigned IRQ_PROT     = 2;
    localparam int unsigned IRQ_ERR      = 3;
    localparam int unsigned IRQ_W        = 4;

    // fixed-role acceptance by line index (0-based)
    function automatic logic fn_legal(input logic [2:0] idx,
                                      input logic [1:0] fn);
        return (fn != FN_FIXED) || (idx < 3'(FIXED_LINES));
    endfunction : fn_legal

endpackage : dio_pkg

/* rtl/edge_detect.sv */
// edge_detect: selectable edge detector for the trigger line
// assumes the input level is already synchronous to clk
module edge_detect
    import dio_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         level,
    input  wire logic         arm,
    input  wire logic [1:0]   sel,
    output logic              hit
);
    logic prev_q;
    logic rise;
    logic fall;

    // edge terms from the held previous level
    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;
    assign hit  = arm & ((sel == EDGE_RISE && rise) ||
                         (sel == EDGE_FALL && fall) ||
                         (sel == EDGE_BOTH && (rise || fall)));

    always_ff @(posedge clk) begin
        if (reset) prev_q <= 1'b0;
        else       prev_q <= level;
    end
endmodule : edge_detect

/* rtl/pulse_bus_if.sv */
// pulse_bus_if: request and busy pair between the core and a pulse stretcher
// assumes both ends share one clock
interface pulse_bus_if;
    logic fire;
    logic active;
    modport core    (output fire, input  active);
    modport stretch (input  fire, output active);
endinterface : pulse_bus_if

/* rtl/pulse_stretch.sv */
// pulse_stretch: turns a one-cycle request into a fixed-length high level
// assumes the request is synchronous to clk
module pulse_stretch
    import dio_pkg::*;
#(
    parameter int unsigned LEN = PULSE_CYC
) (
    input  wire logic         clk,
    input  wire logic         reset,
    pulse_bus_if.stretch      bus
);
    logic [PULSE_W-1:0] cnt_q;
    logic [PULSE_W-1:0] cnt_d;

    // a new request restarts the pulse rather than queueing a second one
    assign cnt_d = bus.fire ? PULSE_W'(LEN) :
                   (cnt_q != '0) ? cnt_q - PULSE_W'(1) : cnt_q;
    assign bus.active = (cnt_q != '0);

    always_ff @(posedge clk) begin
        if (reset) cnt_q <= '0;
        else       cnt_q <= cnt_d;
    end
endmodule : pulse_stretch

/* tb/dio_lines_props.sv */
// dio_lines_props: port-level checks of the digital i/o block
// assumes it is bound to dio_lines and sees only that module's ports
module dio_lines_props
    import dio_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic [3:0]           addr,
    input wire logic [15:0]          wdata,
    input wire logic                 wr,
    input wire logic                 rd,
    input wire logic [15:0]          rdata,
    input wire logic                 meas_done,
    input wire logic                 over_voltage_trip,
    input wire logic                 over_current_trip,
    input wire logic                 over_temp_trip,
    input wire logic                 sense_reversed,
    input wire logic [NUM_LINES-1:0] line_in,
    input wire logic [NUM_LINES-1:0] line_out,
    input wire logic [NUM_LINES-1:0] line_oe,
    input wire logic                 trigger_event,
    input wire logic                 irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] fn_q [3];  // mirrored function of lines 1-3
    logic [1:0] fp_q [3];  // one cycle older, pins follow it
    logic [8:0] d_q  [3];  // cycles since the last accepted event
    wire        prot = over_voltage_trip | over_current_trip |
                       over_temp_trip | sense_reversed;
    wire  [2:0] ev   = {prot, meas_done, 1'b0};
    wire        fwr  = wr && addr == ADDR_FUNC;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence rd_far;
        rd && addr > ADDR_PINS;
    endsequence

    // lines 1-3 accept every code, so a plain copy tracks them exactly
    for (genvar i = 0; i < 3; i++) begin : g_ln
        always_ff @(posedge clk) begin
            if (reset) begin
                fn_q[i] <= FN_FIXED;
                fp_q[i] <= FN_INPUT;
                d_q[i]  <= 9'h000;
            end else begin
                fn_q[i] <= fwr ? wdata[2*i+1 -: 2] : fn_q[i];
                fp_q[i] <= fn_q[i];
                d_q[i]  <= fn_q[i] != FN_FIXED ? 9'h000 :
                           ev[i] ? 9'h001 :
                           d_q[i] != 9'h000 && d_q[i] < 9'h1FF ?
                           d_q[i] + 9'h001 : d_q[i];
            end
        end
        fixed_drive_a: assert property (fn_q[i] == FN_FIXED &&
            fp_q[i] == FN_FIXED |-> line_oe[i] == (i != 0))
            else $error("fixed role drive enable wrong");
        manual_high_a: assert property (fn_q[i] == FN_HIGH &&
            fp_q[i] == FN_HIGH |-> line_oe[i] && line_out[i])
            else $error("manual high not driven high");
        manual_low_a: assert property (fn_q[i] == FN_LOW &&
            fp_q[i] == FN_LOW |-> line_oe[i] && !line_out[i])
            else $error("manual low not driven low");
        input_free_a: assert property (fn_q[i] == FN_INPUT &&
            fp_q[i] == FN_INPUT |-> !line_oe[i])
            else $error("input line still driven");
        // a retrigger keeps the pin high, so the restart cycle is skipped
        if (i > 0) begin : g_pulse
            pulse_span_a: assert property (fn_q[i] == FN_FIXED &&
                fp_q[i] == FN_FIXED && d_q[i] != 9'h001 |->
                line_out[i] == (d_q[i] >= 9'd2 && d_q[i] <= 9'd251))
                else $error("fixed role pulse length wrong");
        end
    end

    rdata_idle_a: assert property (!rd |=> rdata == 16'h0000)
        else $error("read data outside read answer");
    rd_unmapped_a: assert property (rd_far |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    trig_edge_a: assert property (trigger_event |->
        $past(line_in[0]) != $past(line_in[0], 2) ||
        $past(line_in[0], 2) != $past(line_in[0], 3))
        else $error("trigger without an edge on line one");
endmodule : dio_lines_props

/* tb/line_equipment.sv */
// line_equipment: external test gear wired to the six lines
// assumes the bench sets drive enables and levels at clock edges
module line_equipment
    import dio_pkg::*;
(
    input wire logic                 clk,
    input wire logic [NUM_LINES-1:0] drv_en,
    input wire logic [NUM_LINES-1:0] drv_val,
    input wire logic [NUM_LINES-1:0] line_out,
    input wire logic [NUM_LINES-1:0] line_oe,
    output logic [NUM_LINES-1:0]     line_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NUM_LINES-1:0] last_q;
    // no pull on the lines: a floating line toggles so it never looks held
    assign line_in = (line_oe & line_out) | (~line_oe & drv_en & drv_val) |
                     (~line_oe & ~drv_en & ~last_q);
    always_ff @(posedge clk) last_q <= line_in;
endmodule : line_equipment

/* tb/tb_top.sv */
// tb_top: self-checking bench for the six-line digital i/o block
// assumes dio_pkg, the design, the props and the equipment are compiled
module tb_top
    import dio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0]  addr = 4'h0, prot_ev = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        meas_done = 1'b0;
    logic [5:0]  drv_en = 6'h3F, drv_val = 6'h00;
    wire  [15:0] rdata;
    wire  [5:0]  line_in, line_out, line_oe;
    wire         trigger_event, irq;
    int          fails = 0, comparisons = 0;

    dio_lines dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .meas_done(meas_done),
        .over_voltage_trip(prot_ev[0]), .over_current_trip(prot_ev[1]),
        .over_temp_trip(prot_ev[2]), .sense_reversed(prot_ev[3]),
        .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
        .trigger_event(trigger_event), .irq(irq));
    line_equipment gear (.clk(clk), .drv_en(drv_en), .drv_val(drv_val),
        .line_out(line_out), .line_oe(line_oe), .line_in(line_in));

    initial forever #20 clk = ~clk;

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(logic [3:0] a, logic [15:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(logic [3:0] a, logic [15:0] exp, string what);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask : rd_chk

    task automatic irq_chk(logic e, string what);
        repeat (2) @(negedge clk);
        chk(what, {15'h0000, e}, {15'h0000, irq});
    endtask : irq_chk

    task automatic query(logic [2:0] n, logic [15:0] res, logic [15:0] err);
        wr_reg(ADDR_QUERY, {13'h0000, n});
        rd_chk(ADDR_RESULT, res, "query result");
        rd_chk(ADDR_ERROR, err, "query error");
    endtask : query

    task automatic fire(logic [4:0] e);
        @(posedge clk);
        {prot_ev, meas_done} <= e;
        @(posedge clk);
        {prot_ev, meas_done} <= 5'h00;
    endtask : fire

    // pin high time counted at falling edges, bounded against a stuck pin
    task automatic pulse_len(int idx, output int n);
        n = 0;
        for (int k = 0; k < 8 && line_out[idx] !== 1'b1; k++) @(negedge clk);
        while (line_out[idx] === 1'b1 && n < 600) begin
            n++;
            @(negedge clk);
        end
    endtask : pulse_len

    task automatic t_reset;
        rd_chk(ADDR_FUNC, {4'h0, FUNC_RESET}, "func reset");
        rd_chk(ADDR_IRQ_STAT, 16'h0000, "status reset");
        chk("oe reset", 16'h0006, {10'h000, line_oe});
        $display("test reset done");
    endtask : t_reset

    task automatic t_refuse;
        wr_reg(ADDR_FUNC, 16'h0000);
        rd_chk(ADDR_FUNC, 16'h0FC0, "func refused");
        rd_chk(ADDR_IRQ_STAT, 16'h0008, "status error");
        wr_reg(ADDR_IRQ_EN, 16'h0008);
        irq_chk(1'b1, "irq raised");
        wr_reg(ADDR_IRQ_EN, 16'h0000);
        irq_chk(1'b0, "irq masked");
        wr_reg(ADDR_IRQ_EN, 16'h0008);
        wr_reg(ADDR_IRQ_CLR, 16'h0008);
        irq_chk(1'b0, "irq cleared");
        rd_chk(4'hC, 16'h0000, "unmapped read");
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_manual;
        wr_reg(ADDR_FUNC, 16'h0E79);
        drv_val <= 6'b100100;
        repeat (2) @(negedge clk);
        chk("oe manual", 16'h001B, {10'h000, line_oe});
        chk("out manual", 16'h0009, {10'h000, line_out & line_oe});
        rd_chk(ADDR_PINS, 16'h002D, "pins manual");
        query(3'd3, 16'h8001, 16'h0000);
        @(posedge clk);
        drv_val <= 6'b000000;
        query(3'd6, 16'h8000, 16'h0000);
        query(3'd1, 16'h0000, 16'h01FC);
        query(3'd7, 16'h0000, 16'h01FC);
        fire(5'h1F);
        repeat (3) @(negedge clk);
        chk("line2 quiet", 16'h0000, {15'h0000, line_out[1]});
        rd_chk(ADDR_IRQ_STAT, 16'h0008, "events ignored");
        $display("test manual done");
    endtask : t_manual

    task automatic t_pulse;
        int n;
        // gear holds line one high so its release is no falling edge
        @(posedge clk);
        drv_val[0] <= 1'b1;
        wr_reg(ADDR_FUNC, 16'h0FC0);
        rd_chk(ADDR_IRQ_STAT, 16'h0008, "status quiet");
        fire(5'h01);
        pulse_len(1, n);
        chk("done pulse", 16'(PULSE_CYC), 16'(n));
        for (int s = 0; s < 4; s++) begin
            fire(5'h02 << s);
            pulse_len(2, n);
            chk("trip pulse", 16'(PULSE_CYC), 16'(n));
        end
        rd_chk(ADDR_IRQ_STAT, 16'h000E, "status pulses");
        $display("test pulse done");
    endtask : t_pulse

    task automatic t_trig;
        int hits;
        edge_sel_t sel [3] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};
        for (int s = 0; s < 3; s++) begin
            wr_reg(ADDR_EDGE, {14'h0000, sel[s]});
            hits = 0;
            for (int k = 0; k < 12; k++) begin
                @(posedge clk);
                if (k == 2) drv_val[0] <= 1'b1;
                if (k == 7) drv_val[0] <= 1'b0;
                #1 hits += int'(trigger_event === 1'b1);
            end
            chk("trigger count", 16'(s == 2 ? 2 : 1), 16'(hits));
        end
        wr_reg(ADDR_EDGE, 16'h0003);
        rd_chk(ADDR_EDGE, 16'h0002, "edge refused");
        $display("test trigger done");
    endtask : t_trig

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_refuse();
        t_manual();
        t_pulse();
        t_trig();
        final_report();
    end

    // tests need about 1400 cycles, so this only catches a hang
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule : tb_top

bind dio_lines dio_lines_props props (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .meas_done(meas_done), .over_voltage_trip(over_voltage_trip),
    .over_current_trip(over_current_trip), .over_temp_trip(over_temp_trip),
    .sense_reversed(sense_reversed), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe),
    .trigger_event(trigger_event), .irq(irq));
